/* design/cell_voltage_result_regs.sv */
// read-only bank of per-cell voltage result registers behind an ahb-lite slave
// assumes the measurement engine presents a one-cycle store strobe per cell with raw and filtered codes
// What this block does
// - each 14-bit result sits in bits 15:2 of its 16-bit register, msb at bit 15.
// - the full 14-bit code range stands for a 5 V input span, codes passed unscaled from a 5 V converter.
// - result registers are read only and a bus write leaves them unchanged.
// - every cell has its own result register holding its latest value.
// - a cell whose enable is 0 and that was skipped in the scan keeps its stored data.
// - the filter select decides whether reads return the raw or the filtered value.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "cell_result_params.svh"
module cell_voltage_result_regs
    import cell_result_pkg::*;
#(
    parameter int NCELL = `CELL_COUNT
) (
    input wire logic hclk, // bus clock, 50 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data, registered
    output logic hreadyout, // always ready, tied high
    output logic hresp, // always okay, tied low
    input wire logic [NCELL-1:0] meas_store, // per-cell store strobe
    input wire logic [NCELL-1:0] meas_skipped, // cell skipped in this scan
    input wire logic [NCELL*`RES_WIDTH-1:0] raw_code, // raw codes per cell
    input wire logic [NCELL*`RES_WIDTH-1:0] filt_code, // filtered_result_path codes
    output logic [NCELL-1:0] cell_measure_enable, // enables, registered
    output logic readback_filter_select // 1 selects filtered value
);

    ////////////////////////////////////////////////////////////////////////////
    // stored results
    logic [15:0] raw_r [NCELL];
    logic [15:0] raw_nxt [NCELL];
    logic [15:0] filt_r [NCELL];
    logic [15:0] filt_nxt [NCELL];
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    phase_type ph_r;
    phase_type ph_nxt;
    logic wr_r;
    logic wr_nxt;
    logic [7:0] idx_r;
    logic [7:0] idx_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // a raw and a filtered store slot per cell
    genvar g;
    generate
        for (g = 0; g < NCELL; g++) begin : g_cell
            always_comb begin
                raw_nxt[g] = raw_r[g];
                filt_nxt[g] = filt_r[g];
                // a skipped, disabled cell holds its data
                if (meas_store[g] && !(meas_skipped[g] && !ctrl_r[g])) begin
                    raw_nxt[g] = {raw_code[g*`RES_WIDTH +: `RES_WIDTH], 2'b00};
                    filt_nxt[g] = {filt_code[g*`RES_WIDTH +: `RES_WIDTH], 2'b00};
                end
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    raw_r[g] <= `CELL_RESET;
                    filt_r[g] <= `CELL_RESET;
                end else begin
                    raw_r[g] <= raw_nxt[g];
                    filt_r[g] <= filt_nxt[g];
                end
            end
            // low bits never set
            a_low_bits_zero : assert property (@(posedge hclk) disable iff (!hresetn)
                raw_r[g][1:0] == 2'b00 && filt_r[g][1:0] == 2'b00)
                else $error("result low bits not zero");
            // a disabled cell that the scan skipped must keep its raw slot
            a_skip_holds : assert property (@(posedge hclk) disable iff (!hresetn)
                meas_store[g] && meas_skipped[g] && !ctrl_r[g] |=> $stable(raw_r[g]))
                else $error("skipped disabled cell changed");
            // the filtered slot is held too, or a later filtered readback would jump
            a_skip_holds_filt : assert property (@(posedge hclk) disable iff (!hresetn)
                meas_store[g] && meas_skipped[g] && !ctrl_r[g] |=> $stable(filt_r[g]))
                else $error("skipped disabled cell filtered slot changed");
            // the code msb lands at bit 15
            a_store_msb : assert property (@(posedge hclk) disable iff (!hresetn)
                meas_store[g] && !meas_skipped[g] |=>
                raw_r[g][15] == $past(raw_code[g*`RES_WIDTH + `RES_WIDTH - 1]))
                else $error("result msb misplaced");
            // the whole raw code lands in 15:2 whenever the cell is enabled,
            // skipped or not, since only the disabled-and-skipped case is held
            a_store_raw : assert property (@(posedge hclk) disable iff (!hresetn)
                meas_store[g] && ctrl_r[g] |=>
                raw_r[g][15:2] == $past(raw_code[g*`RES_WIDTH +: `RES_WIDTH]))
                else $error("raw slot not stored");
            // the filtered slot follows the filtered code on the same store
            a_store_filt : assert property (@(posedge hclk) disable iff (!hresetn)
                meas_store[g] && ctrl_r[g] |=>
                filt_r[g][15:2] == $past(filt_code[g*`RES_WIDTH +: `RES_WIDTH]))
                else $error("filtered slot not stored");
            // with no strobe for this cell nothing moves: a slot only ever
            // shows the last result of its own cell, never a neighbour's
            a_no_store_hold : assert property (@(posedge hclk) disable iff (!hresetn)
                !meas_store[g] |=> $stable(raw_r[g]) && $stable(filt_r[g]))
                else $error("result changed without a store");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait state, read data computed in the address phase and registered
    //
    // map of the word indices this slave answers (byte address is 4x index):
    //   control word   : enables in the low bits, filter select above them
    //   result words   : one per cell, first cell at the lowest index
    //   anything else  : reads as zero, writes are dropped
    // only haddr[9:2] is decoded, so the map repeats every 1 kbyte; the
    // interconnect is expected to gate hsel so that aliases are never reached.
    // hsize is not looked at: the bank only does whole-word transfers and a
    // narrower access simply acts on the whole word.
    //
    // timing: the read word is picked from the stored slots at the address
    // edge and registered, so hrdata stands for exactly the data phase and
    // falls back to zero after it. the trade is one flop stage of read data
    // against a combinational path from haddr to hrdata.
    // hazard: a read whose address phase overlaps the data phase of a write
    // to the control word still sees the old filter select, because the
    // control word only changes at the end of that data phase.
    //
    // writes: only the control word is writable; a write that names a result
    // word changes nothing, so software cannot corrupt a measurement.
    function automatic logic [31:0] read_word(input logic [7:0] idx);
        logic [31:0] w;
        int k;
        w = 32'h0000_0000;
        k = int'(idx) - int'(`CELL_FIRST_IDX);
        if (idx == `CELL_CTRL_IDX) begin
            w = ctrl_r;
        end else if (k >= 0 && k < NCELL) begin
            w = {16'h0000, ctrl_r[`CTRL_FILT_BIT] ? filt_r[k] : raw_r[k]};
        end
        return w;
    endfunction : read_word

    logic take;
    assign take = hsel && hready && htrans[1];

    always_comb begin
        ph_nxt = take ? PH_DATA : PH_IDLE;
        wr_nxt = take && hwrite;
        idx_nxt = take ? haddr[9:2] : idx_r;
        ctrl_nxt = ctrl_r;
        // only the control word takes writes; result words ignore them
        if (ph_r == PH_DATA && wr_r && idx_r == `CELL_CTRL_IDX) begin
            ctrl_nxt = {23'h000000, hwdata[`CTRL_FILT_BIT], 5'h00, hwdata[2:0]};
        end
        rdata_nxt = 32'h0000_0000;
        if (take && !hwrite) begin
            rdata_nxt = read_word(haddr[9:2]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_r <= PH_IDLE;
            wr_r <= 1'b0;
            idx_r <= 8'h00;
            ctrl_r <= `CTRL_RESET;
            rdata_r <= 32'h0000_0000;
        end else begin
            ph_r <= ph_nxt;
            wr_r <= wr_nxt;
            idx_r <= idx_nxt;
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // outputs straight from flops, hreadyout and hresp tied constant
    always_comb begin
        hrdata = rdata_r;
        hreadyout = 1'b1;
        hresp = 1'b0;
        cell_measure_enable = ctrl_r[NCELL-1:0];
        readback_filter_select = ctrl_r[`CTRL_FILT_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus-side checks

    // an accepted read address phase
    sequence s_read_addr;
        take && !hwrite;
    endsequence

    // an accepted read of one of the result words
    sequence s_cell_read;
        take && !hwrite && haddr[9:2] >= `CELL_FIRST_IDX && haddr[9:2] < `CELL_FIRST_IDX + NCELL;
    endsequence

    // an accepted read of a word that is neither control nor result
    sequence s_unmapped_read;
        take && !hwrite && haddr[9:2] != `CELL_CTRL_IDX
            && !(haddr[9:2] >= `CELL_FIRST_IDX && haddr[9:2] < `CELL_FIRST_IDX + NCELL);
    endsequence

    // an accepted read of the control word
    sequence s_ctrl_read;
        take && !hwrite && haddr[9:2] == `CELL_CTRL_IDX;
    endsequence

    // a write to the second result word while its cell sees no store
    sequence s_four_write;
        take && hwrite && haddr[9:2] == `CELL_FOUR_IDX && !meas_store[1] ##1 !meas_store[1];
    endsequence

    // the data phase of a write to the control word
    sequence s_ctrl_write_data;
        ph_r == PH_DATA && wr_r && idx_r == `CELL_CTRL_IDX;
    endsequence

    // the slave never stretches a transfer and never answers with an error
    a_ready_okay : assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave stalled or answered with an error");

    // a bus write to the second result word never reaches that cell's result slots
    a_write_ignored : assert property (@(posedge hclk) disable iff (!hresetn)
        s_four_write |=> $stable(raw_r[1]) && $stable(filt_r[1]))
        else $error("result register changed by write");

    // the select that was in force at the address edge picks the source
    a_filter_mux : assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && haddr[9:2] == `CELL_THREE_IDX |=>
        hrdata[15:0] == ($past(ctrl_r[`CTRL_FILT_BIT]) ? $past(filt_r[0]) : $past(raw_r[0])))
        else $error("readback source wrong");

    // same check on the last cell, so an index slip in the decode shows up
    a_filter_mux_last : assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && haddr[9:2] == `CELL_FIVE_IDX |=>
        hrdata[15:0] == ($past(ctrl_r[`CTRL_FILT_BIT]) ? $past(filt_r[2]) : $past(raw_r[2])))
        else $error("readback source wrong on last cell");

    // a result word carries zeros above the 16-bit register and in its low bits
    a_cell_read_pad : assert property (@(posedge hclk) disable iff (!hresetn)
        s_cell_read |=> hrdata[31:16] == 16'h0000 && hrdata[1:0] == 2'b00)
        else $error("result word padding not zero");

    // unmapped words read as zero
    a_unmapped_zero : assert property (@(posedge hclk) disable iff (!hresetn)
        s_unmapped_read |=> hrdata == 32'h0000_0000)
        else $error("unmapped word not zero");

    // read data stands only in the data phase of a read
    a_read_idle_zero : assert property (@(posedge hclk) disable iff (!hresetn)
        !(take && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data outside a read data phase");

    // the control word reads back what it holds, nothing else
    a_ctrl_readback : assert property (@(posedge hclk) disable iff (!hresetn)
        s_ctrl_read |=> hrdata[31:9] == 23'h000000 && hrdata[7:NCELL] == '0
        && hrdata[`CTRL_FILT_BIT] == $past(readback_filter_select)
        && hrdata[NCELL-1:0] == $past(cell_measure_enable))
        else $error("control word readback wrong");

    // a control write takes effect at the end of its data phase
    a_ctrl_write : assert property (@(posedge hclk) disable iff (!hresetn)
        s_ctrl_write_data |=> readback_filter_select == $past(hwdata[`CTRL_FILT_BIT])
        && cell_measure_enable == $past(hwdata[NCELL-1:0]))
        else $error("control write not applied");

    // a read in the data phase of nothing still keeps the select steady
    a_select_steady : assert property (@(posedge hclk) disable iff (!hresetn)
        s_read_addr ##1 !(ph_r == PH_DATA && wr_r && idx_r == `CELL_CTRL_IDX) |=> $stable(ctrl_r))
        else $error("control word moved without a write");

endmodule : cell_voltage_result_regs

/* design/cell_result_params.svh */
// constants for the cell voltage result bank: offsets, field positions, reset values
// assumes inclusion by the package and the bank module
`ifndef CELL_RESULT_PARAMS_SVH
`define CELL_RESULT_PARAMS_SVH
// register indices as printed; byte address is four times the index
`define CELL_THREE_IDX 8'h49
`define CELL_FOUR_IDX 8'h4a
`define CELL_FIVE_IDX 8'h4b
// first cell index and cell count of this bank
`define CELL_FIRST_IDX 8'h49
`define CELL_COUNT 3
// control register for enables and filter select
`define CELL_CTRL_IDX 8'h40
`define CTRL_FILT_BIT 8
// result field
`define RES_MSB 15
`define RES_LSB 2
`define RES_WIDTH 14
`define CELL_RESET 16'h0000
`define CTRL_RESET 32'h0000_0007
// full-scale span in millivolts
`define FULL_SCALE_MV 5000
`endif

/* design/cell_result_pkg.sv */
// types shared by the cell voltage result bank
// assumes the params header is on the include path
`include "cell_result_params.svh"
package cell_result_pkg;
    typedef logic [`RES_WIDTH-1:0] code_type;
    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_DATA = 1'b1
    } phase_type;
endpackage : cell_result_pkg

/* testbench/cell_voltage_result_regs_bench.sv */
// bench for the cell voltage result bank: ahb-lite master tasks plus store strobes
// assumes the design package and params header are compiled and on the include path
`timescale 1ns/10ps
`include "cell_result_params.svh"
module cell_voltage_result_regs_bench;
    import cell_result_pkg::*;
    localparam logic [31:0] base = `CELL_FIRST_IDX * 4; // byte address is four times the index
    localparam logic [31:0] ctrl = `CELL_CTRL_IDX * 4;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, readback_filter_select;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, meas_store = 0, meas_skipped = 0, cell_measure_enable;
    logic [41:0] raw_code = 0, filt_code = 0;
    int failures = 0, samples_checked = 0;
    always #10 hclk = ~hclk;
    ////////////////////////////////////////////////////////////////////////////
    // hready loops back from the only slave, as on a single-slave bus
    cell_voltage_result_regs #(.NCELL(3)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .meas_store(meas_store), .meas_skipped(meas_skipped),
        .raw_code(raw_code), .filt_code(filt_code), .cell_measure_enable(cell_measure_enable),
        .readback_filter_select(readback_filter_select));
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic cmp(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // looks at hready mid-cycle so the sample never races the edge; bounded wait
    task automatic wait_ready();
        for (int n = 0; n <= 50; n++) begin
            @(negedge hclk);
            r = hrdata;
            if (hreadyout === 1'b1) break;
            if (n == 50) begin
                failures++;
                give_verdict();
            end
        end
        @(posedge hclk);
    endtask : wait_ready
    // one single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask : bus
    task automatic rd(input logic [31:0] a, input logic [13:0] c);
        bus(1'b0, a, 32'h0);
        cmp(r, {16'h0, c, 2'h0});
        cmp({31'h0, hresp}, 32'h0);
    endtask : rd
    task automatic store(input logic [2:0] s, k, input logic [41:0] rc, fc);
        meas_store <= s;
        meas_skipped <= k;
        raw_code <= rc;
        filt_code <= fc;
        @(posedge hclk);
        meas_store <= 3'h0;
        meas_skipped <= 3'h0;
        @(posedge hclk);
    endtask : store
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int k = 0; k < 3; k++) rd(base + 4 * k, 14'h0);
        cmp({29'h0, cell_measure_enable}, 32'h7);
    endtask : t_reset
    // full-scale, one-lsb and alternating-bit raw codes, raw and filtered different, read back each raw code
    task automatic t_store();
        store(3'h7, 3'h0, {14'h2aaa, 14'h0001, 14'h3fff}, {14'h0abc, 14'h2000, 14'h1555});
        rd(base, 14'h3fff);
        rd(base + 4, 14'h0001);
        rd(base + 8, 14'h2aaa);
    endtask : t_store
    task automatic t_write();
        bus(1'b1, base + 4, 32'hffff_ffff);
        rd(base + 4, 14'h0001);
        rd(32'h1fc, 14'h0);
    endtask : t_write
    task automatic t_filter();
        bus(1'b1, ctrl, 32'h107);
        @(negedge hclk);
        cmp({31'h0, readback_filter_select}, 32'h1);
        @(posedge hclk);
        rd(base, 14'h1555);
        rd(base + 8, 14'h0abc);
    endtask : t_filter
    // cell4 disabled and skipped must hold both slots; cell3 skipped but enabled updates
    task automatic t_skip();
        bus(1'b1, ctrl, 32'h105);
        @(negedge hclk);
        cmp({29'h0, cell_measure_enable}, 32'h5);
        @(posedge hclk);
        store(3'h3, 3'h3, {14'h0, 14'h1111, 14'h0222}, {14'h0, 14'h3333, 14'h0444});
        rd(base + 4, 14'h2000);
        rd(base, 14'h0444);
        bus(1'b1, ctrl, 32'h007);
        rd(base + 4, 14'h0001);
    endtask : t_skip
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_store();
        t_write();
        t_filter();
        t_skip();
        give_verdict();
    end
endmodule : cell_voltage_result_regs_bench
